/* File: inc/qcmd_consts.svh */
`ifndef QCMD_CONSTS_SVH
`define QCMD_CONSTS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_RXQ_CMD 10'h082
`define IDX_TX_PTR 10'h084
`define IDX_RX_TIMER_THR 10'h08c
`define IDX_RX_BYTE_THR 10'h08e
`define IDX_RX_FRAME_THR 10'h09c
`define IDX_IRQ_STATUS 10'h0c0
`define IDX_IRQ_MASK 10'h0c2

// ----------------------------------------------------------------
// receive queue command fields
// ----------------------------------------------------------------
`define BIT_TIMER_HIT 12
`define BIT_BYTE_HIT 11
`define BIT_FRAME_HIT 10
`define BIT_IP_ALIGN 9
`define BIT_TIMER_EN 7
`define BIT_BYTE_EN 6
`define BIT_FRAME_EN 5
`define BIT_AUTO_DEQ 4
`define BIT_DMA_START 3
`define BIT_RELEASE 0

// ----------------------------------------------------------------
// transmit pointer and interrupt fields, threshold limit and reset values
// ----------------------------------------------------------------
`define BIT_TX_AUTOINC 14
`define BIT_RX_IRQ 13
`define TX_PTR_RESET 11'h000
`define TIMER_THR_MAX 16'hcfff
`define TIMER_THR_RESET 16'h0000
`define BYTE_THR_RESET 16'h0000
`define FRAME_THR_RESET 16'h0000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 8
`define TIMER_STEP_NS 1000
`define TIMER_STEP_CYC \
    ((`TIMER_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: inc/qcmd_pkg.sv */
package qcmd_pkg;

    // width of one host access through the frame data port
    typedef enum logic [1:0] {
        ACC_BYTE,
        ACC_WORD,
        ACC_DWORD
    } access_size_t;

endpackage

/* File: logic/queue_command_and_tx_pointer.sv */
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`include "qcmd_consts.svh"

// Behaviour
// - timer cause bit refreshed on status acknowledge
// - byte count cause bit refreshed on acknowledge
// - frame count cause bit refreshed on acknowledge
// - align bit adds two bytes before header
// - timer enable raises receive interrupt past threshold
// - byte enable raises receive interrupt past threshold
// - frame enable raises receive interrupt past threshold
// - auto dequeue skips to next frame
// - writing dma bit opens host dma session
// - open session blocks all other registers
// - release bit frees error frame, self clears
// - autoinc advances pointer by access width
// - pointer resets zero, reloads after enqueue
// - timer threshold in microseconds, max limited
module queue_command_and_tx_pointer
    import qcmd_pkg::*;
#(
    parameter int PTR_W = 11,
    parameter int BCNT_W = 16,
    parameter int FCNT_W = 8
)
(
    input wire logic CLK, // system clock, 125 MHz
    input wire logic SYS_RST, // synchronous reset, active high
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb access phase
    input wire logic PWRITE, // apb direction, high for write
    input wire logic [11:0] PADDR, // apb byte address
    input wire logic [31:0] PWDATA, // apb write data
    output logic [31:0] PRDATA, // apb read data
    output logic PREADY, // apb ready
    output logic PSLVERR, // apb error, unmapped or blocked
    input wire logic [BCNT_W-1:0] RXQ_BYTES, // bytes buffered in rx queue
    input wire logic [FCNT_W-1:0] RXQ_FRAMES, // frames buffered in rx queue
    input wire logic RX_FRAME_READ, // pulse, host read whole frame
    input wire logic RX_RELEASE_DONE, // pulse, error frame freed
    input wire logic DATA_ACCESS, // pulse, data port access
    input wire access_size_t DATA_SIZE, // width of that access
    input wire logic TX_ENQUEUED, // pulse, frame enqueued
    input wire logic [PTR_W-1:0] TX_NEXT_LOC, // next free tx location
    output logic IP_ALIGN, // insert two bytes before header
    output logic RX_DEQUEUE, // pulse, advance rx read pointer
    output logic RX_RELEASE_REQ, // level, free current error frame
    output logic DMA_ACTIVE, // host dma session open
    output logic [PTR_W-1:0] TX_POINTER, // transmit frame pointer
    output logic IRQ // level interrupt, unmasked status set
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    // pointer field sits in bits 13..0 and counts sit in 16-bit fields
    if (PTR_W < 3 || PTR_W > 14 || BCNT_W > 16 || FCNT_W > 16)
    begin : g_bad_params
        $error("queue_command_and_tx_pointer: unsupported widths");
    end

    // ----------------------------------------------------------------
    // control and status state
    // ----------------------------------------------------------------
    logic ip_align_offset_enable; // header offset control
    logic rx_timer_threshold_enable; // timer cause enable
    logic rx_bytecount_threshold_enable; // byte cause enable
    logic rx_framecount_threshold_enable; // frame cause enable
    logic auto_dequeue_enable; // automatic dequeue control
    logic dma_open; // host dma session open
    logic release_error_frame; // release request pending
    logic rx_timer_threshold_hit; // latched timer cause
    logic rx_bytecount_threshold_hit; // latched byte cause
    logic rx_framecount_threshold_hit; // latched frame cause
    logic tx_pointer_autoinc; // pointer auto increment
    logic [PTR_W-1:0] tx_pointer_value; // transmit frame pointer
    logic [15:0] rx_timer_threshold_value; // microseconds
    logic [15:0] rx_bytecount_threshold_value; // bytes
    logic [15:0] rx_framecount_threshold_value; // frames
    logic rx_irq_status; // sticky receive interrupt status
    logic rx_irq_mask; // receive interrupt mask
    logic any_hit_q; // previous combined threshold state

    // timer state
    logic [7:0] step_cnt; // cycles within one microsecond
    logic [15:0] elapsed_us; // microseconds since first frame

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    wire [9:0] idx = PADDR[11:2]; // word index
    wire setup = PSEL & ~PENABLE; // first cycle of a transfer
    wire done = PSEL & PENABLE & PREADY; // completing edge
    wire sel_cmd = idx == `IDX_RXQ_CMD;
    wire sel_ptr = idx == `IDX_TX_PTR;
    wire sel_tthr = idx == `IDX_RX_TIMER_THR;
    wire sel_bthr = idx == `IDX_RX_BYTE_THR;
    wire sel_fthr = idx == `IDX_RX_FRAME_THR;
    wire sel_stat = idx == `IDX_IRQ_STATUS;
    wire sel_mask = idx == `IDX_IRQ_MASK;
    wire mapped = sel_cmd | sel_ptr | sel_tthr | sel_bthr | sel_fthr
        | sel_stat | sel_mask;
    // while a session is open only the command register answers
    wire blocked = dma_open & ~sel_cmd;
    wire refused = ~mapped | blocked;
    wire wr = done & PWRITE & ~refused;
    wire rd = done & ~PWRITE & ~refused;
    wire [15:0] wd = PWDATA[15:0];

    // ----------------------------------------------------------------
    // threshold comparisons
    // ----------------------------------------------------------------
    // counts must exceed, not merely reach, their thresholds
    wire timer_hit = rx_timer_threshold_enable
        & (RXQ_FRAMES != '0)
        & (elapsed_us > rx_timer_threshold_value);
    wire byte_hit = rx_bytecount_threshold_enable
        & (16'(RXQ_BYTES) > rx_bytecount_threshold_value);
    wire frame_hit = rx_framecount_threshold_enable
        & (16'(RXQ_FRAMES) > rx_framecount_threshold_value);
    wire any_hit = timer_hit | byte_hit | frame_hit;
    wire rx_irq_event = any_hit & ~any_hit_q; // new crossing
    wire step_end = step_cnt == 8'(`TIMER_STEP_CYC - 1);
    wire [15:0] thr_clamped = (wd > `TIMER_THR_MAX) ? `TIMER_THR_MAX
        : wd;

    // acknowledge: write of one to the receive status bit
    wire ack = wr & sel_stat & wd[`BIT_RX_IRQ];

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    // dma start is write-only and reads back as zero
    wire [15:0] rd_cmd = {3'h0, rx_timer_threshold_hit,
        rx_bytecount_threshold_hit, rx_framecount_threshold_hit,
        ip_align_offset_enable, 1'h0, rx_timer_threshold_enable,
        rx_bytecount_threshold_enable, rx_framecount_threshold_enable,
        auto_dequeue_enable, 3'h0, release_error_frame};
    wire [15:0] rd_ptr = {1'h0, tx_pointer_autoinc, 14'(tx_pointer_value)};
    wire [15:0] rd_stat = {2'h0, rx_irq_status, 13'h0000};
    wire [15:0] rd_mask = {2'h0, rx_irq_mask, 13'h0000};
    wire [15:0] rd_mux = sel_cmd ? rd_cmd
        : sel_ptr ? rd_ptr
        : sel_tthr ? rx_timer_threshold_value
        : sel_bthr ? rx_bytecount_threshold_value
        : sel_fthr ? rx_framecount_threshold_value
        : sel_stat ? rd_stat
        : sel_mask ? rd_mask
        : 16'h0000;

    // ----------------------------------------------------------------
    // transmit pointer next value
    // ----------------------------------------------------------------
    logic [PTR_W-1:0] step_size; // bytes per data port access
    always_comb
    begin
        case (DATA_SIZE)
            ACC_BYTE: step_size = PTR_W'(1);
            ACC_WORD: step_size = PTR_W'(2);
            ACC_DWORD: step_size = PTR_W'(4);
            default: step_size = PTR_W'(0); // unused encoding
        endcase
    end

    // enqueue wins: the frame location moves on regardless
    logic [PTR_W-1:0] next_pointer; // pointer after this cycle
    always_comb
    begin
        if (TX_ENQUEUED)
            next_pointer = TX_NEXT_LOC;
        else if (wr & sel_ptr)
            next_pointer = wd[PTR_W-1:0]; // host placement
        else if (tx_pointer_autoinc & DATA_ACCESS)
            next_pointer = tx_pointer_value + step_size;
        else
            next_pointer = tx_pointer_value; // hold
    end

    // ----------------------------------------------------------------
    // apb answer, registered: one wait-free access phase
    // ----------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0000_0000;
        end
        else
        begin
            PREADY <= setup; // ready in the cycle after setup
            PSLVERR <= setup & refused;
            PRDATA <= (setup & ~refused & ~PWRITE)
                ? {16'h0000, rd_mux} : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // receive queue command register
    // ----------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            ip_align_offset_enable <= 1'b0;
            rx_timer_threshold_enable <= 1'b0;
            rx_bytecount_threshold_enable <= 1'b0;
            rx_framecount_threshold_enable <= 1'b0;
            auto_dequeue_enable <= 1'b0;
            dma_open <= 1'b0;
        end
        else if (wr & sel_cmd)
        begin
            ip_align_offset_enable <= wd[`BIT_IP_ALIGN];
            rx_timer_threshold_enable <= wd[`BIT_TIMER_EN];
            rx_bytecount_threshold_enable <= wd[`BIT_BYTE_EN];
            rx_framecount_threshold_enable <= wd[`BIT_FRAME_EN];
            auto_dequeue_enable <= wd[`BIT_AUTO_DEQ];
            // one opens the session, zero closes it
            dma_open <= wd[`BIT_DMA_START];
        end
    end

    // release request: done pulse clears, a new write wins over it
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
            release_error_frame <= 1'b0;
        else if (wr & sel_cmd & wd[`BIT_RELEASE])
            release_error_frame <= 1'b1;
        else if (RX_RELEASE_DONE)
            release_error_frame <= 1'b0;
    end

    // cause bits are a snapshot taken at each acknowledge
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            rx_timer_threshold_hit <= 1'b0;
            rx_bytecount_threshold_hit <= 1'b0;
            rx_framecount_threshold_hit <= 1'b0;
        end
        else if (ack)
        begin
            rx_timer_threshold_hit <= timer_hit;
            rx_bytecount_threshold_hit <= byte_hit;
            rx_framecount_threshold_hit <= frame_hit;
        end
    end

    // ----------------------------------------------------------------
    // threshold and mask registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            rx_timer_threshold_value <= `TIMER_THR_RESET;
            rx_bytecount_threshold_value <= `BYTE_THR_RESET;
            rx_framecount_threshold_value <= `FRAME_THR_RESET;
            rx_irq_mask <= 1'b0;
        end
        else
        begin
            // larger timer settings are clipped to the largest legal one
            if (wr & sel_tthr)
                rx_timer_threshold_value <= thr_clamped;
            if (wr & sel_bthr)
                rx_bytecount_threshold_value <= wd;
            if (wr & sel_fthr)
                rx_framecount_threshold_value <= wd;
            if (wr & sel_mask)
                rx_irq_mask <= wd[`BIT_RX_IRQ];
        end
    end

    // ----------------------------------------------------------------
    // duration timer, microsecond steps from the first buffered frame
    // ----------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (SYS_RST || RXQ_FRAMES == '0)
        begin
            step_cnt <= 8'h00;
            elapsed_us <= 16'h0000;
        end
        else if (step_end)
        begin
            step_cnt <= 8'h00;
            // saturate rather than wrap back below the threshold
            if (elapsed_us != 16'hffff)
                elapsed_us <= elapsed_us + 16'h0001;
        end
        else
            step_cnt <= step_cnt + 8'h01;
    end

    // ----------------------------------------------------------------
    // interrupt status: sticky, cleared by read, set wins
    // ----------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            any_hit_q <= 1'b0;
            rx_irq_status <= 1'b0;
            IRQ <= 1'b0;
        end
        else
        begin
            any_hit_q <= any_hit;
            if (rx_irq_event)
                rx_irq_status <= 1'b1;
            else if (rd & sel_stat)
                rx_irq_status <= 1'b0;
            IRQ <= (rx_irq_status | rx_irq_event) & rx_irq_mask
                & ~(rd & sel_stat & ~rx_irq_event);
        end
    end

    // ----------------------------------------------------------------
    // transmit pointer and side outputs
    // ----------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            tx_pointer_autoinc <= 1'b0;
            tx_pointer_value <= PTR_W'(`TX_PTR_RESET);
            RX_DEQUEUE <= 1'b0;
            IP_ALIGN <= 1'b0;
            RX_RELEASE_REQ <= 1'b0;
            DMA_ACTIVE <= 1'b0;
            TX_POINTER <= PTR_W'(`TX_PTR_RESET);
        end
        else
        begin
            if (wr & sel_ptr)
                tx_pointer_autoinc <= wd[`BIT_TX_AUTOINC];
            tx_pointer_value <= next_pointer;
            // dequeue only when the host has read the frame out
            RX_DEQUEUE <= auto_dequeue_enable & RX_FRAME_READ;
            // copies keep every output straight from a flip-flop
            IP_ALIGN <= ip_align_offset_enable;
            RX_RELEASE_REQ <= release_error_frame;
            DMA_ACTIVE <= dma_open;
            TX_POINTER <= tx_pointer_value;
        end
    end

endmodule

/* File: tb/qcmd_checker_assertions.sv */
`timescale 1ns/1ps
`include "qcmd_consts.svh"
module qcmd_checker
    import qcmd_pkg::*;
#(
    parameter int PTR_W = 11
)
(
    input wire logic CLK, // clock
    input wire logic SYS_RST, // sync reset
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb access
    input wire logic PWRITE, // apb write
    input wire logic [11:0] PADDR, // apb address
    input wire logic [31:0] PRDATA, // apb read data
    input wire logic PREADY, // apb ready
    input wire logic PSLVERR, // apb error
    input wire logic RX_FRAME_READ, // frame read pulse
    input wire logic RX_RELEASE_DONE, // frame freed pulse
    input wire logic DATA_ACCESS, // data port pulse
    input wire logic TX_ENQUEUED, // enqueue pulse
    input wire logic [PTR_W-1:0] TX_NEXT_LOC, // reload value
    input wire logic RX_DEQUEUE, // dequeue pulse
    input wire logic RX_RELEASE_REQ, // release level
    input wire logic DMA_ACTIVE, // session open
    input wire logic [PTR_W-1:0] TX_POINTER // tx pointer
);
    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    wire apb_done = PSEL && PENABLE && PREADY; // completing edge
    wire apb_wr = apb_done && PWRITE; // write takes effect
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    sequence setup_s;
        PSEL && !PENABLE;
    endsequence
    sequence quiet_s;
        !DATA_ACCESS && !TX_ENQUEUED && !apb_wr;
    endsequence
    // ------------------------------------------------
    // assertions
    // ------------------------------------------------
    chk_ready_timing: assert property (setup_s |=> PREADY)
        else $error("ready missing after setup");
    chk_ready_only: assert property (!(PSEL && !PENABLE) |=> !PREADY)
        else $error("ready without setup");
    chk_err_ready: assert property (PSLVERR |-> PREADY)
        else $error("error outside ready");
    chk_err_data: assert property (PREADY && PSLVERR |-> PRDATA == 32'h0)
        else $error("refused read returned data");
    chk_session_block: assert property (
        PSEL && !PENABLE && DMA_ACTIVE && $past(DMA_ACTIVE)
        && !$past(apb_done) && PADDR[11:2] != `IDX_RXQ_CMD |=> PSLVERR)
        else $error("access not refused in session");
    chk_dequeue_cause: assert property (
        RX_DEQUEUE |-> $past(RX_FRAME_READ))
        else $error("dequeue without frame read");
    chk_release_clear: assert property (
        RX_RELEASE_DONE && !apb_wr |-> ##2 !RX_RELEASE_REQ)
        else $error("release request not cleared");
    chk_ptr_reload: assert property (TX_ENQUEUED
        |-> ##2 TX_POINTER == $past(TX_NEXT_LOC, 2))
        else $error("pointer not reloaded");
    chk_ptr_hold: assert property (
        quiet_s [*2] |=> $stable(TX_POINTER))
        else $error("pointer moved while idle");
endmodule

bind queue_command_and_tx_pointer qcmd_checker #(.PTR_W(PTR_W)) u_chk (
    .CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .RX_FRAME_READ(RX_FRAME_READ),
    .RX_RELEASE_DONE(RX_RELEASE_DONE), .DATA_ACCESS(DATA_ACCESS),
    .TX_ENQUEUED(TX_ENQUEUED), .TX_NEXT_LOC(TX_NEXT_LOC),
    .RX_DEQUEUE(RX_DEQUEUE), .RX_RELEASE_REQ(RX_RELEASE_REQ),
    .DMA_ACTIVE(DMA_ACTIVE), .TX_POINTER(TX_POINTER));

/* File: tb/qcmd_queue_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------
// far-side queue manager, frees errored frames
// ------------------------------------------------
module qcmd_queue_model
(
    input wire logic clk, // system clock
    input wire logic rst, // sync reset, active high
    input wire logic release_req, // free request from block
    input wire logic [7:0] delay, // cycles spent freeing
    output logic release_done // pulse, memory freed
);
    int cnt; // cycles spent so far
    // slow on purpose: software must poll, not assume
    always @(posedge clk)
    begin
        release_done <= 1'b0;
        if (rst || !release_req || release_done)
            cnt <= 0;
        else if (cnt == int'(delay))
        begin
            release_done <= 1'b1;
            cnt <= 0;
        end
        else
            cnt <= cnt + 1;
    end
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ps
`include "qcmd_consts.svh"
module tb
    import qcmd_pkg::*;
;
    logic CLK = 0, SYS_RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic [11:0] PADDR = 0; // byte address
    logic [31:0] PWDATA = 0, PRDATA, rd; // rd: last read
    logic PREADY, PSLVERR, er, RX_FRAME_READ = 0, RX_RELEASE_DONE;
    logic DATA_ACCESS = 0, TX_ENQUEUED = 0, IP_ALIGN, RX_DEQUEUE, IRQ;
    logic RX_RELEASE_REQ, DMA_ACTIVE;
    logic [15:0] RXQ_BYTES = 0; // live byte count
    logic [7:0] RXQ_FRAMES = 0, rel_delay = 8'h0c; // frames, free time
    access_size_t DATA_SIZE = ACC_BYTE; // data port width
    logic [10:0] TX_NEXT_LOC = 0, TX_POINTER;
    int errors = 0, n_tests = 0, cyc = 0, ptr, thr, k, c, i;
    logic [9:0] regs [8] = '{`IDX_RXQ_CMD, `IDX_TX_PTR,
        `IDX_RX_TIMER_THR, `IDX_RX_BYTE_THR, `IDX_RX_FRAME_THR,
        `IDX_IRQ_STATUS, `IDX_IRQ_MASK, 10'h086}; // last is unmapped

    queue_command_and_tx_pointer u_dut (.CLK(CLK), .SYS_RST(SYS_RST),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .RXQ_BYTES(RXQ_BYTES), .RXQ_FRAMES(RXQ_FRAMES),
        .RX_FRAME_READ(RX_FRAME_READ), .RX_RELEASE_DONE(RX_RELEASE_DONE),
        .DATA_ACCESS(DATA_ACCESS), .DATA_SIZE(DATA_SIZE),
        .TX_ENQUEUED(TX_ENQUEUED), .TX_NEXT_LOC(TX_NEXT_LOC),
        .IP_ALIGN(IP_ALIGN), .RX_DEQUEUE(RX_DEQUEUE),
        .RX_RELEASE_REQ(RX_RELEASE_REQ), .DMA_ACTIVE(DMA_ACTIVE),
        .TX_POINTER(TX_POINTER), .IRQ(IRQ));
    qcmd_queue_model u_queue (.clk(CLK), .rst(SYS_RST),
        .release_req(RX_RELEASE_REQ), .delay(rel_delay),
        .release_done(RX_RELEASE_DONE));

    // ------------------------------------------------
    // clock, watchdog, reporting
    // ------------------------------------------------
    always #4 CLK = ~CLK;
    // runs need about 1700 cycles; a hang stops here
    always @(posedge CLK)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            errors++;
            end_sim();
        end
    end
    task end_sim();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task chk_pin(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            errors++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask
    task chk_reg(input string nm, input logic [31:0] e);
        chk_pin(nm, e, rd);
    endtask
    // one apb transfer; waits for ready however long it takes
    task apb(input logic w, input logic [9:0] idx, input logic [15:0] d);
        @(posedge CLK);
        PSEL <= 1;
        PENABLE <= 0;
        PWRITE <= w;
        PADDR <= {idx, 2'b00};
        PWDATA <= {16'h0000, d};
        @(posedge CLK);
        PENABLE <= 1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 0;
        PENABLE <= 0;
    endtask
    // one data port access, then let the pointer settle
    task data_acc(input int sz);
        @(posedge CLK);
        DATA_ACCESS <= 1;
        DATA_SIZE <= access_size_t'(sz);
        @(posedge CLK);
        DATA_ACCESS <= 0;
        repeat (2) @(posedge CLK);
    endtask

    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial
    begin
        k = $urandom(99916);
        repeat (4) @(posedge CLK);
        SYS_RST <= 0;
        for (i = 0; i < 8; i++)
        begin
            apb(0, regs[i], 0);
            chk_reg("reset value", 0);
            chk_pin("unmapped err", i == 7, er);
        end
        $display("test reset done");
        rel_delay <= 8'($urandom_range(10, 20));
        apb(1, regs[7], 0); // write to the unmapped index, refused with no effect
        apb(1, `IDX_RXQ_CMD, 16'hfe19);
        apb(0, `IDX_RXQ_CMD, 0);
        chk_reg("cmd", 32'h0211);
        chk_pin("align", 1, IP_ALIGN);
        chk_pin("session", 1, DMA_ACTIVE);
        apb(1, `IDX_TX_PTR, 16'h0123);
        chk_pin("blocked err", 1, er);
        k = 0;
        do
        begin
            apb(0, `IDX_RXQ_CMD, 0);
            k++;
        end
        while (rd[0] !== 1'b0 && k < 40);
        chk_pin("release cleared", 0, rd[0]);
        apb(1, `IDX_RXQ_CMD, 16'h0010);
        repeat (2) @(posedge CLK);
        chk_pin("session", 0, DMA_ACTIVE);
        chk_pin("align off", 0, IP_ALIGN);
        apb(0, `IDX_TX_PTR, 0);
        chk_reg("ptr kept", 0);
        for (k = 1; k >= 0; k--)
        begin
            apb(1, `IDX_RXQ_CMD, 16'(k << 4));
            @(posedge CLK);
            RX_FRAME_READ <= 1;
            @(posedge CLK);
            RX_FRAME_READ <= 0;
            @(posedge CLK);
            chk_pin("dequeue", k, RX_DEQUEUE);
        end
        $display("test session done");
        apb(1, `IDX_TX_PTR, 16'hffff);
        apb(0, `IDX_TX_PTR, 0);
        chk_reg("ptr", 32'h47ff);
        ptr = 'h7ff;
        for (i = 0; i < 16; i++)
        begin
            k = $urandom_range(0, 2);
            data_acc(k);
            ptr = (ptr + (1 << k)) & 'h7ff;
            chk_pin("tx ptr", ptr, TX_POINTER);
        end
        ptr = $urandom_range(0, 2047);
        TX_NEXT_LOC <= 11'(ptr);
        TX_ENQUEUED <= 1;
        @(posedge CLK);
        TX_ENQUEUED <= 0;
        repeat (2) @(posedge CLK);
        chk_pin("reload", ptr, TX_POINTER);
        apb(1, `IDX_TX_PTR, 16'h0005);
        data_acc(2);
        chk_pin("manual ptr", 5, TX_POINTER);
        $display("test pointer done");
        apb(1, `IDX_RX_TIMER_THR, 16'hffff);
        apb(0, `IDX_RX_TIMER_THR, 0);
        chk_reg("timer clip", 32'hcfff);
        // last pass repeats the timer cause with the mask off
        for (c = 0; c < 4; c++)
        begin
            k = c % 3;
            thr = (k == 0) ? 2 : $urandom_range(1, 200);
            apb(1, `IDX_IRQ_MASK, (c < 3) ? 16'h2000 : 16'h0000);
            apb(1, regs[2 + k], 16'(thr));
            apb(1, `IDX_RXQ_CMD, 16'(1 << (7 - k)));
            RXQ_BYTES <= (k == 1) ? 16'(thr) : 16'h0000;
            RXQ_FRAMES <= (k == 2) ? 8'(thr) : 8'(k == 0);
            repeat (20) @(posedge CLK);
            chk_pin("irq at thr", 0, IRQ);
            RXQ_BYTES <= (k == 1) ? 16'(thr + 1) : 16'h0000;
            RXQ_FRAMES <= (k == 2) ? 8'(thr + 1) : 8'(k == 0);
            i = 0;
            while (IRQ !== 1'b1 && i < 1000)
            begin
                @(posedge CLK);
                i++;
            end
            chk_pin("irq", c < 3, IRQ);
            if (k == 0 && c < 3)
                chk_pin("timer early", 1, i > 250);
            apb(0, `IDX_IRQ_STATUS, 0);
            chk_reg("status", 32'h2000);
            apb(1, `IDX_IRQ_STATUS, 16'h2000);
            apb(0, `IDX_RXQ_CMD, 0);
            chk_reg("cause", (1 << (7 - k)) | (1 << (12 - k)));
            chk_pin("irq cleared", 0, IRQ);
            apb(0, `IDX_IRQ_STATUS, 0);
            chk_reg("status clear", 0);
            RXQ_BYTES <= 0;
            RXQ_FRAMES <= 0;
            apb(1, `IDX_RXQ_CMD, 0);
        end
        $display("test interrupt done");
        end_sim();
    end
endmodule
